// File: bench/ssr_host_model.sv
`timescale 1ns/1ps
// two-wire host: drives the clock and pulls data low, never drives it high
module ssr_host_model (
    input wire logic ref_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // signals change just after an edge; halves of 8 cycles clear the slave synchronisers
    task automatic gap(int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic bit_x(logic d_low, output logic s);
        sda_low_o = d_low;
        gap(4);
        scl_o = 1'b1;
        gap(4);
        s = sda_i;
        gap(4);
        scl_o = 1'b0;
        gap(4);
    endtask
    // also serves as repeated start, since it first releases data with the clock low
    task automatic start_c();
        sda_low_o = 1'b0;
        gap(4);
        scl_o = 1'b1;
        gap(8);
        sda_low_o = 1'b1;
        gap(8);
        scl_o = 1'b0;
        gap(4);
    endtask
    task automatic stop_c();
        sda_low_o = 1'b1;
        gap(4);
        scl_o = 1'b1;
        gap(8);
        sda_low_o = 1'b0;
        gap(8);
    endtask
    task automatic wr(logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(!b[i], s);
        bit_x(1'b0, s);
        ack = !s;
    endtask
    // the last byte gets a nack so the slave lets go of the line
    task automatic rd_b(logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b0, s);
            b[i] = s;
        end
        bit_x(!last, s);
    endtask
    task automatic read_seq(logic [6:0] a, logic [7:0] ptr, int n, output logic ok,
                            output logic [7:0] rd[$]);
        logic k;
        logic [7:0] v;
        rd.delete();
        start_c();
        wr({a, 1'b0}, ok);
        if (ok) begin
            wr(ptr, k);
            ok = ok & k;
            start_c();
            wr({a, 1'b1}, k);
            ok = ok & k;
            for (int i = 0; i < n; i++) begin
                rd_b(i == n - 1, v);
                rd.push_back(v);
            end
        end
        stop_c();
    endtask
endmodule

// File: bench/ssr_sync_route_bench.sv
`timescale 1ns/1ps
module ssr_sync_route_bench
    import ssr_pkg::*;
;
    logic ref_clk_i, sys_rst_i, hs, gr, vs, co, sa0, pol, g_sel, v_sel, cv_sel, ok, en;
    logic [7:0] thr, e;
    logic [7:0] rd[$];
    ssr_sync_out_t sync_o;
    logic sda_o, sda_oe;
    wire scl, sda_low, sda_line;
    int n_fail = 0;
    int checks = 0;
    logic [7:0] q_exp[$];
    string q_name[$];
    logic [7:0] got_v;
    event seen;
    // pull-up: the line is high unless some party pulls it low
    assign sda_line = !(sda_low || (sda_oe && !sda_o));
    ssr_sync_route u_ssr_sync_route (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .clk_en_i(en), .hsync_i(hs), .green_embedded_sync_i(gr), .vsync_i(vs),
        .coast_i(co), .scl_i(scl), .sda_i(sda_line), .sa0_i(sa0), .sync_pol_i(pol),
        .green_sync_sel_i(g_sel), .vsync_sep_sel_i(v_sel), .coast_vsync_sel_i(cv_sel),
        .sep_thresh_i(thr), .sync_o(sync_o), .sda_o(sda_o), .sda_oe_o(sda_oe));
    ssr_host_model u_ssr_host_model (.ref_clk_i(ref_clk_i), .sda_i(sda_line),
        .scl_o(scl), .sda_low_o(sda_low));
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = !ref_clk_i;
    end
    task automatic tick(int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic note(string nm, logic [7:0] x);
        q_name.push_back(nm);
        q_exp.push_back(x);
    endtask
    task automatic result(logic [7:0] v);
        got_v = v;
        -> seen;
        #0.1;
    endtask
    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // the watcher owns every comparison; notes are consumed oldest first
    initial forever begin
        @(seen);
        checks++;
        if (q_exp.size() == 0) begin
            n_fail++;
            $display("mismatch result with no note expected none seen %h", got_v);
        end else begin
            e = q_exp.pop_front();
            if (got_v !== e) begin
                n_fail++;
                $display("mismatch %s expected %h seen %h", q_name.pop_front(), e, got_v);
            end else void'(q_name.pop_front());
        end
    end
    // a bound that runs out is a failure and ends the run at once
    task automatic wait_vs(logic x, int n);
        int k;
        k = 0;
        while (sync_o.vsync !== x && k < n) begin
            tick(1);
            k++;
        end
        note("vsync", {7'h00, x});
        result({7'h00, sync_o.vsync});
        if (k == n) begin
            n_fail++;
            wrap_up();
        end
    endtask
    // composite sync on hsync; pulses of two ticks or less must never reach threshold 4
    task automatic sep_run(logic p);
        pol = p;
        hs = !p;
        tick(150);
        repeat (4) begin
            hs = p;
            tick(50);
            hs = !p;
            tick(100);
            note("vsync short", 8'h00);
            result({7'h00, sync_o.vsync});
        end
        hs = p;
        tick(95);
        note("vsync early", 8'h00);
        result({7'h00, sync_o.vsync});
        wait_vs(1'b1, 40);
        tick(300);
        hs = !p;
        tick(50);
        hs = p;
        tick(100);
        note("vsync serration", 8'h01);
        result({7'h00, sync_o.vsync});
        hs = !p;
        tick(95);
        note("vsync hold", 8'h01);
        result({7'h00, sync_o.vsync});
        wait_vs(1'b0, 40);
    endtask
    initial begin
        {hs, gr, vs, co, sa0, pol} = 6'h3F;
        {g_sel, v_sel, cv_sel} = 3'h0;
        en = 1'b1;
        thr = 8'hC8;
        sys_rst_i = 1'b1;
        void'($urandom(32'h9465));
        tick(20);
        note("sync_o in reset", 8'h00);
        result({5'h00, sync_o} | {7'h00, sda_oe});
        sys_rst_i = 1'b0;
        tick(3);
        // every select combination twice, random levels on the four sync pins
        for (int i = 0; i < 16; i++) begin
            {hs, gr, vs, co} = 4'($urandom);
            {g_sel, v_sel, cv_sel} = 3'(i);
            tick(4);
            ok = v_sel ? 1'b0 : vs;
            note("sync_o", {5'h00, g_sel ? gr : hs, cv_sel ? ok : co, ok});
            result({5'h00, sync_o});
        end
        // enable low must freeze the routed outputs while the four sync pins move
        en = 1'b0;
        note("sync_o frozen", {5'h00, g_sel ? gr : hs, cv_sel ? ok : co, ok});
        {hs, gr, vs, co} = ~{hs, gr, vs, co};
        tick(6);
        result({5'h00, sync_o});
        en = 1'b1;
        {g_sel, v_sel, cv_sel} = 3'h3;
        thr = 8'h04;
        sep_run(1'b1);
        sep_run(1'b0);
        // register read back from the pointer onward, across unmapped places
        {sa0, g_sel, v_sel, cv_sel} = 4'($urandom);
        thr = 8'($urandom);
        tick(4);
        u_ssr_host_model.read_seq({SLAVE_ADDR_HI, sa0}, 8'h0D, 5, ok, rd);
        note("addr ack", 8'h01);
        result({7'h00, ok});
        note("reg 0D", 8'h00);
        note("reg 0E", {4'h0, g_sel, 2'b00, v_sel});
        note("reg 0F", {2'b00, cv_sel, 5'h00});
        note("reg 10", 8'h00);
        note("reg 11", thr);
        for (int i = 0; i < 5; i++) result(rd.size() > i ? rd[i] : 8'hXX);
        u_ssr_host_model.read_seq({SLAVE_ADDR_HI, sa0}, 8'h11, 1, ok, rd);
        note("reg 11 single", thr);
        result(rd.size() > 0 ? rd[0] : 8'hXX);
        u_ssr_host_model.read_seq({SLAVE_ADDR_HI, !sa0}, 8'h0E, 1, ok, rd);
        note("foreign addr ack", 8'h00);
        result({7'h00, ok});
        tick(10);
        wrap_up();
    end
endmodule

// File: core/ssr_pkg.sv
package ssr_pkg;
    // timing: separator tick derived from the reference clock
    localparam int REF_CLK_HZ = 125_000_000;
    localparam int SEP_CLK_HZ = 5_000_000;
    localparam int SEP_DIV = REF_CLK_HZ / SEP_CLK_HZ;
    localparam logic [4:0] SEP_DIV_LAST = 5'(SEP_DIV - 1);
    localparam logic [4:0] DIV_RST = 5'h00;
    // separator counter limits and reset value
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    // serial register offsets and field positions
    localparam logic [7:0] REG_SYNC_CTL = 8'h0E;
    localparam logic [7:0] REG_COAST_CTL = 8'h0F;
    localparam logic [7:0] REG_THRESH = 8'h11;
    localparam int BIT_GREEN_SEL = 3;
    localparam int BIT_VSEP_SEL = 0;
    localparam int BIT_CV_SEL = 5;
    localparam logic [7:0] REG_RST = 8'h00;
    // serial slave address upper six bits, lowest bit from the strap
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h26;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam logic [3:0] BIT_CNT_BYTE = 4'h8;

    typedef enum logic [1:0] {
        SEP_SEEK = 2'b00,
        SEP_HELD = 2'b01
    } ssr_sep_state_t;

    typedef enum logic [2:0] {
        SER_IDLE = 3'b000,
        SER_ADDR = 3'b001,
        SER_ADDR_ACK = 3'b011,
        SER_PTR = 3'b010,
        SER_PTR_ACK = 3'b110,
        SER_READ = 3'b111,
        SER_MACK = 3'b101
    } ssr_ser_state_t;

    typedef struct packed {
        logic coast;
        logic vsync;
        logic green;
        logic hsync;
        logic sda;
        logic scl;
        logic sa0;
    } ssr_pins_t;

    typedef struct packed {
        logic hsync;
        logic coast_vsync;
        logic vsync;
    } ssr_sync_out_t;
endpackage

// File: core/ssr_sync_route.sv
`timescale 1ns/1ps
module ssr_sync_route
    import ssr_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic hsync_i,
    input wire logic green_embedded_sync_i,
    input wire logic vsync_i,
    input wire logic coast_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sa0_i,
    input wire logic sync_pol_i,
    input wire logic green_sync_sel_i,
    input wire logic vsync_sep_sel_i,
    input wire logic coast_vsync_sel_i,
    input wire logic [7:0] sep_thresh_i,
    output ssr_sync_out_t sync_o,
    output logic sda_o,
    output logic sda_oe_o
);
    ssr_pins_t pin_raw, pin_meta_r, pin_s_r;
    logic scl_d_r, sda_d_r;
    logic [4:0] div_r;
    logic tick_r;
    logic [7:0] cnt_r;
    ssr_sep_state_t sep_st_r;
    ssr_sync_out_t sync_r;
    ssr_ser_state_t ser_st_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r, tx_r, ptr_r, rd_byte;
    logic rw_r, sda_oe_r;
    logic hs_mux, vs_mux, sync_act, sep_tick;
    logic scl_rise, scl_fall, ser_start, ser_stop;

    assign pin_raw = {coast_i, vsync_i, green_embedded_sync_i, hsync_i, sda_i, scl_i, sa0_i};

    // two-stage synchronisers; all pins idle high so no false start at release
    for (genvar g = 0; g < $bits(ssr_pins_t); g++) begin : g_sync
        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                pin_meta_r[g] <= 1'b1;
                pin_s_r[g] <= 1'b1;
            end else if (clk_en_i) begin
                pin_meta_r[g] <= pin_raw[g];
                pin_s_r[g] <= pin_meta_r[g];
            end
        end
    end

    // muxes 1 and 2 have separate control bits (green_sync_sel_i, vsync_sep_sel_i), separator input normalised to active high
    assign hs_mux = green_sync_sel_i ? pin_s_r.green : pin_s_r.hsync;
    assign sync_act = hs_mux ~^ sync_pol_i;
    assign vs_mux = vsync_sep_sel_i ? (sep_st_r == SEP_HELD) : pin_s_r.vsync;
    assign sep_tick = clk_en_i & tick_r;

    // registered sync outputs
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sync_r <= '0;
        end else if (clk_en_i) begin
            sync_r.hsync <= hs_mux;
            sync_r.vsync <= vs_mux;
            sync_r.coast_vsync <= coast_vsync_sel_i ? vs_mux : pin_s_r.coast;
        end
    end
    assign sync_o = sync_r;

    // 5 MHz tick as a one-cycle enable; avoids a second clock domain
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            div_r <= DIV_RST;
            tick_r <= 1'b0;
        end else if (clk_en_i) begin
            if (div_r == SEP_DIV_LAST) begin
                div_r <= DIV_RST;
                tick_r <= 1'b1;
            end else begin
                div_r <= div_r + 5'h01;
                tick_r <= 1'b0;
            end
        end
    end

    // separator integrator; a threshold of zero detects on the next tick
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cnt_r <= CNT_RST;
            sep_st_r <= SEP_SEEK;
        end else if (sep_tick) begin
            case (sep_st_r)
                SEP_SEEK: begin
                    if (cnt_r >= sep_thresh_i) begin
                        sep_st_r <= SEP_HELD;
                        cnt_r <= CNT_RST;
                    end else if (sync_act) begin
                        cnt_r <= (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 8'h01;
                    end else begin
                        cnt_r <= (cnt_r == CNT_RST) ? cnt_r : cnt_r - 8'h01;
                    end
                end
                SEP_HELD: begin
                    if (cnt_r >= sep_thresh_i) begin
                        sep_st_r <= SEP_SEEK;
                        cnt_r <= CNT_RST;
                    end else if (!sync_act) begin
                        cnt_r <= (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 8'h01;
                    end else begin
                        // active sync between serration pulses pulls the count back rather than clearing it
                        cnt_r <= (cnt_r == CNT_RST) ? cnt_r : cnt_r - 8'h01;
                    end
                end
                default: begin
                    sep_st_r <= SEP_SEEK;
                    cnt_r <= CNT_RST;
                end
            endcase
        end
    end

    // serial line edges, taken from the synchronised copies only
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else if (clk_en_i) begin
            scl_d_r <= pin_s_r.scl;
            sda_d_r <= pin_s_r.sda;
        end
    end
    assign scl_rise = clk_en_i & pin_s_r.scl & ~scl_d_r;
    assign scl_fall = clk_en_i & ~pin_s_r.scl & scl_d_r;
    assign ser_start = clk_en_i & scl_d_r & pin_s_r.scl & sda_d_r & ~pin_s_r.sda;
    assign ser_stop = clk_en_i & scl_d_r & pin_s_r.scl & ~sda_d_r & pin_s_r.sda;

    // read-back view of the configuration ports
    always_comb begin
        rd_byte = REG_RST;
        if (ptr_r == REG_SYNC_CTL) begin
            rd_byte[BIT_GREEN_SEL] = green_sync_sel_i;
            rd_byte[BIT_VSEP_SEL] = vsync_sep_sel_i;
        end else if (ptr_r == REG_COAST_CTL) begin
            rd_byte[BIT_CV_SEL] = coast_vsync_sel_i;
        end else if (ptr_r == REG_THRESH) begin
            rd_byte = sep_thresh_i;
        end
    end

    // serial slave: pointer write then auto-incrementing reads; data writes are not acked
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ser_st_r <= SER_IDLE;
            bit_cnt_r <= BIT_CNT_RST;
            shift_r <= REG_RST;
            tx_r <= REG_RST;
            ptr_r <= REG_RST;
            rw_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (ser_start) begin
            ser_st_r <= SER_ADDR;
            bit_cnt_r <= BIT_CNT_RST;
            sda_oe_r <= 1'b0;
        end else if (ser_stop) begin
            ser_st_r <= SER_IDLE;
            sda_oe_r <= 1'b0;
        end else if (scl_rise) begin
            shift_r <= {shift_r[6:0], pin_s_r.sda};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (ser_st_r == SER_MACK && pin_s_r.sda) begin
                ser_st_r <= SER_IDLE; // host nack ends the read
            end
        end else if (scl_fall) begin
            case (ser_st_r)
                SER_ADDR: begin
                    if (bit_cnt_r == BIT_CNT_BYTE) begin
                        if (shift_r[7:1] == {SLAVE_ADDR_HI, pin_s_r.sa0}) begin
                            sda_oe_r <= 1'b1;
                            rw_r <= shift_r[0];
                            ser_st_r <= SER_ADDR_ACK;
                        end else begin
                            ser_st_r <= SER_IDLE;
                        end
                    end
                end
                SER_ADDR_ACK: begin
                    bit_cnt_r <= BIT_CNT_RST;
                    if (rw_r) begin
                        tx_r <= rd_byte;
                        sda_oe_r <= ~rd_byte[7];
                        ser_st_r <= SER_READ;
                    end else begin
                        sda_oe_r <= 1'b0;
                        ser_st_r <= SER_PTR;
                    end
                end
                SER_PTR: begin
                    if (bit_cnt_r == BIT_CNT_BYTE) begin
                        ptr_r <= shift_r;
                        sda_oe_r <= 1'b1;
                        ser_st_r <= SER_PTR_ACK;
                    end
                end
                SER_PTR_ACK: begin
                    sda_oe_r <= 1'b0;
                    ser_st_r <= SER_IDLE;
                end
                SER_READ: begin
                    if (bit_cnt_r == BIT_CNT_BYTE) begin
                        sda_oe_r <= 1'b0;
                        ptr_r <= ptr_r + 8'h01;
                        ser_st_r <= SER_MACK;
                    end else begin
                        tx_r <= {tx_r[6:0], 1'b0};
                        sda_oe_r <= ~tx_r[6];
                    end
                end
                SER_MACK: begin
                    bit_cnt_r <= BIT_CNT_RST;
                    tx_r <= rd_byte;
                    sda_oe_r <= ~rd_byte[7];
                    ser_st_r <= SER_READ;
                end
                default: begin
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_r;

    a_hsync_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        clk_en_i |=> sync_o.hsync ==
            ($past(green_sync_sel_i) ? $past(pin_s_r.green) : $past(pin_s_r.hsync)))
        else $error("hsync route wrong");
    a_coast_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (clk_en_i && !coast_vsync_sel_i) |=> sync_o.coast_vsync == $past(pin_s_r.coast))
        else $error("coast route wrong");
    a_vsync_route: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (clk_en_i && vsync_sep_sel_i) |=> sync_o.vsync == ($past(sep_st_r) == SEP_HELD))
        else $error("vsync route wrong");
    a_tick_spacing: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i || !clk_en_i)
        tick_r |=> !tick_r [*8])
        else $error("separator tick too fast");
    a_seek_count: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (sep_tick && sep_st_r == SEP_SEEK && sync_act && cnt_r < sep_thresh_i && cnt_r != CNT_MAX)
        |=> cnt_r == $past(cnt_r) + 8'h01)
        else $error("search count did not rise");
    a_detect_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (sep_tick && sep_st_r == SEP_SEEK && cnt_r >= sep_thresh_i)
        |=> sep_st_r == SEP_HELD && cnt_r == CNT_RST)
        else $error("detection missed");
    a_release_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (sep_tick && sep_st_r == SEP_HELD && cnt_r >= sep_thresh_i)
        |=> sep_st_r == SEP_SEEK && cnt_r == CNT_RST)
        else $error("release missed");
    a_count_floor: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (sep_tick && sep_st_r == SEP_SEEK && !sync_act && cnt_r == CNT_RST && sep_thresh_i != CNT_RST)
        |=> cnt_r == CNT_RST)
        else $error("count went below zero");
    a_reset_state: assert property (@(posedge ref_clk_i)
        sys_rst_i |=> cnt_r == CNT_RST && sep_st_r == SEP_SEEK && !sda_oe_o)
        else $error("reset state wrong");
    a_ptr_advance: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (scl_fall && ser_st_r == SER_READ && bit_cnt_r == BIT_CNT_BYTE)
        |=> ptr_r == $past(ptr_r) + 8'h01 && ser_st_r == SER_MACK)
        else $error("pointer did not advance");

    c_vsync_found: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        sep_st_r == SEP_SEEK ##1 sep_st_r == SEP_HELD);
    c_vsync_gone: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        sep_st_r == SEP_HELD ##1 sep_st_r == SEP_SEEK);
    c_second_byte: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ser_st_r == SER_MACK ##1 ser_st_r == SER_READ);
endmodule
